// File: include/gpiw_pkg.sv
/*
  gpiw_pkg: shared constants, encodings and carrier types of the
  pin interrupt and wake detection block.
  Assumes a single 100 MHz core clock and a port of up to 32 pins.
*/
package gpiw_pkg;
  // ==========================================================
  // sizes
  localparam int GPIW_MAX_PINS = 32;
  localparam int GPIW_DEF_PINS = 32;

  // ==========================================================
  // field encodings
  localparam logic GPIW_MODE_LEVEL = 1'h0;
  localparam logic GPIW_MODE_EDGE  = 1'h1;
  localparam logic GPIW_POL_FALL   = 1'h0;
  localparam logic GPIW_POL_RISE   = 1'h1;
  localparam logic GPIW_SEL_A      = 1'h0;
  localparam logic GPIW_SEL_B      = 1'h1;

  // ==========================================================
  // reset values
  localparam logic [GPIW_MAX_PINS-1:0] GPIW_MODE_RST = 32'h0000_0000;
  localparam logic [GPIW_MAX_PINS-1:0] GPIW_POL_RST  = 32'h0000_0000;
  localparam logic [GPIW_MAX_PINS-1:0] GPIW_SEL_RST  = 32'h0000_0000;
  localparam logic [GPIW_MAX_PINS-1:0] GPIW_IEN_RST  = 32'h0000_0000;
  localparam logic [GPIW_MAX_PINS-1:0] GPIW_WKEN_RST = 32'h0000_0000;

  // ==========================================================
  // configuration write targets
  typedef enum logic [3:0] {
    GPIW_T_MODE,
    GPIW_T_POLARITY,
    GPIW_T_CHANNEL,
    GPIW_T_IEN,
    GPIW_T_IEN_SET,
    GPIW_T_IEN_CLR,
    GPIW_T_PEND_CLR,
    GPIW_T_WKEN,
    GPIW_T_WKEN_SET,
    GPIW_T_WKEN_CLR
  } gpiw_target_e;

  // one configuration write, applied in the cycle it is valid
  typedef struct packed {
    logic                     valid;
    gpiw_target_e             target;
    logic [GPIW_MAX_PINS-1:0] data;
  } gpiw_cmd_s;

  // interrupt and wake request bundle towards the system
  typedef struct packed {
    logic irq_a;
    logic irq_b;
    logic wake;
  } gpiw_req_s;
endpackage

// File: rtl/gpiw_setclr_reg.sv
/*
  gpiw_setclr_reg: register bank written directly or through
  write-one-to-set and write-one-to-clear strobes.
  Assumes at most one of the three strobes is high in a cycle.
*/
`timescale 1ns/1ps
module gpiw_setclr_reg
  import gpiw_pkg::*;
#(
  parameter int               WIDTH   = GPIW_DEF_PINS,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             wr,
  input  wire logic             set,
  input  wire logic             clr,
  input  wire logic [WIDTH-1:0] data,
  output      logic [WIDTH-1:0] value
);
  // ==========================================================
  // elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least one");
  end

  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } gpiw_scr_s;

  gpiw_scr_s state_reg;
  gpiw_scr_s state_next;

  // ==========================================================
  // next value: direct write, or per-bit set / clear
  always_comb begin
    state_next = state_reg;
    if (wr) begin
      state_next.bits = data;
    end else if (set) begin
      state_next.bits = state_reg.bits | data;   // zero bits untouched
    end else if (clr) begin
      state_next.bits = state_reg.bits & ~data;  // zero bits untouched
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.bits <= RST_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg.bits;
endmodule

// File: rtl/gpiw_pin_cell.sv
/*
  gpiw_pin_cell: one pin's edge detectors and pending flop.
  Assumes the pin level is synchronous to the core clock.
*/
`timescale 1ns/1ps
module gpiw_pin_cell
  import gpiw_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic mode,
  input  wire logic polarity,
  input  wire logic irq_en,
  input  wire logic clear,
  output      logic pending,
  output      logic edge_hit
);
  typedef struct packed {
    logic primed;  // prev holds a real sample
    logic prev;
    logic rise;
    logic fall;
    logic pend;
  } gpiw_cell_s;

  gpiw_cell_s state_reg;
  gpiw_cell_s state_next;
  logic       rise_ev;
  logic       fall_ev;
  logic       trig;

  // ==========================================================
  // detection, latching and clearing
  always_comb begin
    state_next        = state_reg;
    state_next.primed = 1'b1;
    state_next.prev   = pin;
    rise_ev = state_reg.primed & ~state_reg.prev & pin;
    fall_ev = state_reg.primed & state_reg.prev & ~pin;
    // clear re-arms both detectors; a fresh edge still wins
    if (clear) begin
      state_next.pend = 1'b0;
      state_next.rise = 1'b0;
      state_next.fall = 1'b0;
    end
    if (rise_ev) begin
      state_next.rise = 1'b1;
    end
    if (fall_ev) begin
      state_next.fall = 1'b1;
    end
    // trigger condition from mode and polarity
    if (mode == GPIW_MODE_EDGE) begin
      trig = (polarity == GPIW_POL_RISE) ? state_next.rise : state_next.fall;
    end else begin
      trig = (polarity == GPIW_POL_RISE) ? pin : ~pin;
    end
    // only enabled pins may set pending; a set flop is kept
    if (irq_en && trig) begin
      state_next.pend = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pending  = state_reg.pend;
  assign edge_hit = (polarity == GPIW_POL_RISE) ? state_reg.rise : state_reg.fall;
endmodule

// File: rtl/gpiw_top.sv
/*
  gpiw_top: per-pin interrupt and wake detection of a GPIO port.
  Configuration arrives as one write command per cycle on plain
  ports; pin levels are synchronous to CORE_CLK; requests go to
  the interrupt controller and the power manager as levels.
*/
// Notes on behaviour
// - interrupt detection ignores function-enable and output-enable settings
// - every pin has independent configuration and detection
// - cleared enable blocks pending set; a set pending flop keeps requesting
// - enable-clearer ones clear enable bits, zeros leave them
// - enable-setter ones set enable bits, zeros leave them
// - set enable lets the trigger condition set pending
// - pending clear clears pending flop and both edge detectors
// - mode bit picks level or edge triggering
// - polarity bit picks rising or falling condition
// - channel bit routes pending to request channel A or B
// - read-only channel A and channel B status words show pending pins
// - wake ignores function-enable and output-enable settings
// - wake uses edge detectors chosen by polarity, latching transitions
// - mode zero is level, one is edge
// - polarity one is rising, zero is falling
// - channel bit set means B, clear means A
// - set wake enable lets an edge raise the wake request
`timescale 1ns/1ps
module gpiw_top
  import gpiw_pkg::*;
#(
  parameter int PINS = GPIW_DEF_PINS
) (
  input  wire logic            CORE_CLK,
  input  wire logic            RST_N,
  input  wire logic [PINS-1:0] PIN_LEVEL,
  input  wire gpiw_cmd_s       CFG_CMD,
  output      gpiw_req_s       REQ,
  output      logic [PINS-1:0] CHANNEL_A_STATUS,
  output      logic [PINS-1:0] CHANNEL_B_STATUS,
  output      logic [PINS-1:0] PIN_IRQ_ENABLE,
  output      logic [PINS-1:0] WAKE_ENABLE,
  output      logic [PINS-1:0] TRIGGER_MODE_SELECT,
  output      logic [PINS-1:0] TRIGGER_POLARITY,
  output      logic [PINS-1:0] CHANNEL_SELECT
);
  // ==========================================================
  // elaboration check
  if (PINS < 1 || PINS > GPIW_MAX_PINS) begin : g_bad_pins
    $error("PINS must lie between 1 and the carrier width");
  end

  typedef struct packed {
    logic [PINS-1:0] mode;
    logic [PINS-1:0] polarity;
    logic [PINS-1:0] chan;
    logic [PINS-1:0] stat_a;
    logic [PINS-1:0] stat_b;
    gpiw_req_s       req;
  } gpiw_top_s;

  gpiw_top_s       state_reg;
  gpiw_top_s       state_next;
  logic [PINS-1:0] wr_data;
  logic            wr_ien;
  logic            set_ien;
  logic            clr_ien;
  logic            wr_wken;
  logic            set_wken;
  logic            clr_wken;
  logic [PINS-1:0] pend_clear;
  logic [PINS-1:0] ien;
  logic [PINS-1:0] wken;
  logic [PINS-1:0] pending;
  logic [PINS-1:0] edge_hit;

  // ==========================================================
  // command decode: one strobe per enable-bank target, a mask for pending clear
  assign wr_data  = CFG_CMD.data[PINS-1:0];
  assign wr_ien   = CFG_CMD.valid && (CFG_CMD.target == GPIW_T_IEN);
  assign set_ien  = CFG_CMD.valid && (CFG_CMD.target == GPIW_T_IEN_SET);
  assign clr_ien  = CFG_CMD.valid && (CFG_CMD.target == GPIW_T_IEN_CLR);
  assign wr_wken  = CFG_CMD.valid && (CFG_CMD.target == GPIW_T_WKEN);
  assign set_wken = CFG_CMD.valid && (CFG_CMD.target == GPIW_T_WKEN_SET);
  assign clr_wken = CFG_CMD.valid && (CFG_CMD.target == GPIW_T_WKEN_CLR);
  // write-one pending clear, zeros leave pins alone
  assign pend_clear = (CFG_CMD.valid && (CFG_CMD.target == GPIW_T_PEND_CLR)) ? wr_data : '0;

  // ==========================================================
  // interrupt enable and wake enable banks
  gpiw_setclr_reg #(
    .WIDTH   (PINS),
    .RST_VAL (GPIW_IEN_RST[PINS-1:0])
  ) u_ien (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .wr    (wr_ien),
    .set   (set_ien),
    .clr   (clr_ien),
    .data  (wr_data),
    .value (ien)
  );

  gpiw_setclr_reg #(
    .WIDTH   (PINS),
    .RST_VAL (GPIW_WKEN_RST[PINS-1:0])
  ) u_wken (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .wr    (wr_wken),
    .set   (set_wken),
    .clr   (clr_wken),
    .data  (wr_data),
    .value (wken)
  );

  // ==========================================================
  // one detection cell per pin, fed straight from the pin level
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    gpiw_pin_cell u_cell (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .pin      (PIN_LEVEL[i]),
      .mode     (state_reg.mode[i]),
      .polarity (state_reg.polarity[i]),
      .irq_en   (ien[i]),
      .clear    (pend_clear[i]),
      .pending  (pending[i]),
      .edge_hit (edge_hit[i])
    );
  end

  // ==========================================================
  // configuration writes, status words and request lines
  always_comb begin
    state_next = state_reg;
    if (CFG_CMD.valid) begin
      unique case (CFG_CMD.target)
        GPIW_T_MODE: begin
          state_next.mode = wr_data;
        end
        GPIW_T_POLARITY: begin
          state_next.polarity = wr_data;
        end
        GPIW_T_CHANNEL: begin
          state_next.chan = wr_data;
        end
        default: begin
          state_next.mode = state_reg.mode;  // other targets handled above
        end
      endcase
    end
    // status words split pending flops by channel
    state_next.stat_a = pending & ~state_reg.chan;
    state_next.stat_b = pending & state_reg.chan;
    // request lines stay up while any routed pending flop is set
    state_next.req.irq_a = |(pending & ~state_reg.chan);
    state_next.req.irq_b = |(pending & state_reg.chan);
    // wake on an armed edge of an enabled pin
    state_next.req.wake = |(edge_hit & wken);
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg.mode     <= GPIW_MODE_RST[PINS-1:0];
      state_reg.polarity <= GPIW_POL_RST[PINS-1:0];
      state_reg.chan     <= GPIW_SEL_RST[PINS-1:0];
      state_reg.stat_a   <= '0;
      state_reg.stat_b   <= '0;
      state_reg.req      <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign REQ                 = state_reg.req;
  assign CHANNEL_A_STATUS    = state_reg.stat_a;
  assign CHANNEL_B_STATUS    = state_reg.stat_b;
  assign PIN_IRQ_ENABLE      = ien;
  assign WAKE_ENABLE         = wken;
  assign TRIGGER_MODE_SELECT = state_reg.mode;
  assign TRIGGER_POLARITY    = state_reg.polarity;
  assign CHANNEL_SELECT      = state_reg.chan;
endmodule

// File: verif/gpiw_top_asserts.sv
/*
  gpiw_top_asserts: port-level checker of gpiw_top.
  Assumes it is bound onto gpiw_top, with one clock and async reset.
*/
`timescale 1ns/1ps
module gpiw_top_asserts
  import gpiw_pkg::*;
#(
  parameter int PINS = GPIW_DEF_PINS
) (
  input wire logic            CORE_CLK,
  input wire logic            RST_N,
  input wire logic [PINS-1:0] PIN_LEVEL,
  input wire gpiw_cmd_s       CFG_CMD,
  input wire gpiw_req_s       REQ,
  input wire logic [PINS-1:0] CHANNEL_A_STATUS,
  input wire logic [PINS-1:0] CHANNEL_B_STATUS,
  input wire logic [PINS-1:0] PIN_IRQ_ENABLE,
  input wire logic [PINS-1:0] WAKE_ENABLE,
  input wire logic [PINS-1:0] TRIGGER_MODE_SELECT,
  input wire logic [PINS-1:0] TRIGGER_POLARITY,
  input wire logic [PINS-1:0] CHANNEL_SELECT
);
  // ==========================================================
  // helpers
  logic [PINS-1:0] wr_d;
  logic [PINS-1:0] clr_v;
  logic [PINS-1:0] st;
  // command data, pending-clear mask and union of both status words
  assign wr_d  = CFG_CMD.data[PINS-1:0];
  assign clr_v = (CFG_CMD.valid && CFG_CMD.target == GPIW_T_PEND_CLR) ? wr_d : '0;
  assign st    = CHANNEL_A_STATUS | CHANNEL_B_STATUS;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  // ==========================================================
  // properties
  a_ien_set: assert property (
    CFG_CMD.valid && CFG_CMD.target == GPIW_T_IEN_SET |=> PIN_IRQ_ENABLE == ($past(PIN_IRQ_ENABLE) | $past(wr_d)))
    else $error("enable set result wrong");
  a_ien_clr: assert property (
    CFG_CMD.valid && CFG_CMD.target == GPIW_T_IEN_CLR |=> PIN_IRQ_ENABLE == ($past(PIN_IRQ_ENABLE) & ~$past(wr_d)))
    else $error("enable clear result wrong");
  a_mode_load: assert property (
    CFG_CMD.valid && CFG_CMD.target == GPIW_T_MODE |=> TRIGGER_MODE_SELECT == $past(wr_d))
    else $error("mode write not taken");
  a_pol_load: assert property (
    CFG_CMD.valid && CFG_CMD.target == GPIW_T_POLARITY |=> TRIGGER_POLARITY == $past(wr_d))
    else $error("polarity write not taken");
  a_irq_a_or: assert property (REQ.irq_a == (|CHANNEL_A_STATUS))
    else $error("channel a request not or of status");
  a_irq_b_or: assert property (REQ.irq_b == (|CHANNEL_B_STATUS))
    else $error("channel b request not or of status");
  a_chan_apart: assert property ((CHANNEL_A_STATUS & CHANNEL_B_STATUS) == '0)
    else $error("pin shown on both channels");
  a_route_b: assert property ((CHANNEL_B_STATUS & ~$past(CHANNEL_SELECT)) == '0)
    else $error("channel b status on pin routed to a");
  a_route_a: assert property ((CHANNEL_A_STATUS & $past(CHANNEL_SELECT)) == '0)
    else $error("channel a status on pin routed to b");
  a_en_gates: assert property ((st & ~$past(st) & ~$past(PIN_IRQ_ENABLE, 2)) == '0)
    else $error("pending set while disabled");
  a_pend_holds: assert property (($past(st) & ~st & ~$past(clr_v, 2)) == '0)
    else $error("pending dropped without clear");
  a_wake_gated: assert property (REQ.wake |-> $past(WAKE_ENABLE) != '0)
    else $error("wake without wake enable");

  c_irq_a: cover property ($rose(REQ.irq_a));
  c_irq_b: cover property ($rose(REQ.irq_b));
  c_wake: cover property ($rose(REQ.wake));
endmodule

// File: verif/gpiw_far_end.sv
/*
  gpiw_far_end: behavioural interrupt controller and power manager.
  Assumes the request levels of gpiw_top on the same clock.
*/
`timescale 1ns/1ps
module gpiw_far_end
  import gpiw_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire gpiw_req_s  req,
  output      logic [1:0] served,
  output      logic       woke
);
  // channel a outranks channel b
  assign served = req.irq_a ? 2'h1 : (req.irq_b ? 2'h2 : 2'h0);
  // power manager remembers any wake request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      woke <= 1'b0;
    end else begin
      woke <= woke | req.wake;
    end
  end
endmodule

// File: verif/testbench.sv
/*
  testbench: directed test of gpiw_top with the far-end model.
  Assumes the checker and far-end model are compiled before it.
*/
`timescale 1ns/1ps
bind gpiw_top gpiw_top_asserts #(.PINS(PINS)) u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PIN_LEVEL(PIN_LEVEL),
  .CFG_CMD(CFG_CMD), .REQ(REQ), .CHANNEL_A_STATUS(CHANNEL_A_STATUS), .CHANNEL_B_STATUS(CHANNEL_B_STATUS),
  .PIN_IRQ_ENABLE(PIN_IRQ_ENABLE), .WAKE_ENABLE(WAKE_ENABLE), .TRIGGER_MODE_SELECT(TRIGGER_MODE_SELECT),
  .TRIGGER_POLARITY(TRIGGER_POLARITY), .CHANNEL_SELECT(CHANNEL_SELECT));
module testbench
  import gpiw_pkg::*;
;
  localparam int PINS = 8;
  logic            clk        = 1'b0;
  logic            rst_n      = 1'b0;
  logic [PINS-1:0] pins       = 8'h06;
  gpiw_cmd_s       cmd        = '0;
  gpiw_req_s       req;
  logic [PINS-1:0] st_a, st_b, ien, wken;
  logic [1:0]      served;
  logic            woke;
  logic [PINS-1:0] mode_q;
  logic [PINS-1:0] pol_q;
  logic [PINS-1:0] chan_q;
  int              fail_count = 0;
  int              compares   = 0;

  // ==========================================================
  // clock, design and far end
  always #5 clk = ~clk;
  gpiw_top #(.PINS(PINS)) dut (.CORE_CLK(clk), .RST_N(rst_n), .PIN_LEVEL(pins), .CFG_CMD(cmd), .REQ(req),
    .CHANNEL_A_STATUS(st_a), .CHANNEL_B_STATUS(st_b), .PIN_IRQ_ENABLE(ien), .WAKE_ENABLE(wken),
    .TRIGGER_MODE_SELECT(mode_q), .TRIGGER_POLARITY(pol_q), .CHANNEL_SELECT(chan_q));
  gpiw_far_end far (.clk(clk), .rst_n(rst_n), .req(req), .served(served), .woke(woke));

  // ==========================================================
  // access tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // one configuration write, taken at the second edge
  task automatic wr(input gpiw_target_e t, input logic [PINS-1:0] d);
    @(posedge clk);
    cmd <= '{1'b1, t, 32'(d)};
    @(posedge clk);
    cmd.valid <= 1'b0;
    #1;
  endtask
  task automatic drive(input logic [PINS-1:0] v);
    @(posedge clk);
    pins <= v;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk("ien", 8'h00, ien);
    chk("req", 3'h0, req);
    $display("test reset done");
    wr(GPIW_T_IEN, 8'h0f);
    wr(GPIW_T_IEN_SET, 8'h30);
    chk("ien", 8'h3f, ien);
    wr(GPIW_T_IEN_CLR, 8'h05);
    chk("ien", 8'h3a, ien);
    wr(GPIW_T_WKEN, 8'h01);
    wr(GPIW_T_WKEN_SET, 8'h02);
    wr(GPIW_T_WKEN_CLR, 8'h01);
    chk("wken", 8'h02, wken);
    // wake stays off until the wake test arms it
    wr(GPIW_T_WKEN_CLR, 8'hff);
    chk("wken", 8'h00, wken);
    $display("test set clear done");
    wr(GPIW_T_IEN_CLR, 8'hff);
    wr(GPIW_T_PEND_CLR, 8'hff);
    wr(GPIW_T_MODE, 8'h07);
    wr(GPIW_T_POLARITY, 8'h01);
    wr(GPIW_T_CHANNEL, 8'h02);
    chk("mode", 8'h07, mode_q);
    chk("pol", 8'h01, pol_q);
    chk("chan", 8'h02, chan_q);
    wr(GPIW_T_IEN, 8'h03);
    chk("st_a", 8'h00, st_a);
    drive(8'h05);
    tick(2);
    chk("st_a", 8'h01, st_a);
    chk("st_b", 8'h02, st_b);
    chk("req", 3'h6, req);
    chk("served", 2'h1, served);
    wr(GPIW_T_IEN_CLR, 8'h03);
    tick(2);
    chk("st_a", 8'h01, st_a);
    wr(GPIW_T_PEND_CLR, 8'h02);
    tick(1);
    chk("st_b", 8'h00, st_b);
    chk("st_a", 8'h01, st_a);
    $display("test edge done");
    wr(GPIW_T_PEND_CLR, 8'hff);
    wr(GPIW_T_MODE, 8'h00);
    wr(GPIW_T_POLARITY, 8'h08);
    wr(GPIW_T_CHANNEL, 8'h08);
    wr(GPIW_T_IEN, 8'h08);
    tick(2);
    chk("st_b", 8'h00, st_b);
    drive(8'h0d);
    tick(2);
    chk("st_b", 8'h08, st_b);
    wr(GPIW_T_PEND_CLR, 8'h08);
    tick(2);
    chk("st_b", 8'h08, st_b);
    drive(8'h05);
    wr(GPIW_T_PEND_CLR, 8'h08);
    tick(1);
    chk("st_b", 8'h00, st_b);
    $display("test level done");
    wr(GPIW_T_POLARITY, 8'h10);
    wr(GPIW_T_PEND_CLR, 8'hff);
    wr(GPIW_T_WKEN, 8'h10);
    tick(1);
    chk("wake", 1'b0, req.wake);
    chk("woke", 1'b0, woke);
    drive(8'h15);
    tick(2);
    chk("wake", 1'b1, req.wake);
    tick(1);
    chk("woke", 1'b1, woke);
    wr(GPIW_T_WKEN_CLR, 8'h10);
    tick(1);
    chk("wake", 1'b0, req.wake);
    $display("test wake done");
    give_verdict();
  end
endmodule
